// ### rtl/lin_diag_pkg.sv
// Purpose: Shared constants for the LIN diagnostic flag bank.
// Assumes: Two channels, system clock at 25 MHz.
// Notes:   Fixed status positions are used by the RTL; the bench uses literals.

package lin_diag_pkg;

    // ==========================================================
    // Structure
    localparam int CHANNELS     = 2;
    localparam int FAULT_W      = 5;
    localparam int FLAG_W       = 9;
    localparam int FIX_W        = 16;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ      = 25;
    localparam int T_DOM_US     = 10;
    localparam int DOM_CYCLES   = T_DOM_US * CLK_MHZ;
    localparam int DOM_CNT_W    = 9;
    localparam logic [DOM_CNT_W-1:0] DOM_LIMIT =
        DOM_CNT_W'(DOM_CYCLES);

    // ==========================================================
    // Fault input order (index into the fault vector)
    localparam int FLT_SHORT_GND = 0;
    localparam int FLT_OVERTEMP  = 1;
    localparam int FLT_RXD_LOW   = 2;
    localparam int FLT_RXD_HIGH  = 3;
    localparam int FLT_TXD_DOM   = 4;

    // ==========================================================
    // Flag word layout returned on a channel read
    localparam int FLD_DOM_CLAMP = 0;
    localparam int FLD_STATE     = 1;
    localparam int FLD_WU_RX     = 2;
    localparam int FLD_WAKE_SRC  = 3;
    localparam int FLD_FAULT_LO  = 4;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 9'h000;

    // ==========================================================
    // Fixed status word bit positions
    localparam int FIX_LIN_GROUP = 11;
    localparam int FIX_CH1       = 5;
    localparam int FIX_CH0       = 4;
    localparam logic [FIX_W-1:0] FIX_RST = 16'h0000;

endpackage

// ### rtl/lin_link_front.sv
// Purpose: Link-clock front end: samples bus pins, marks wake events.
// Assumes: lin_clk may stop outside frames; rst_n is from the clk domain.
// Notes:   Wake events leave as a toggle, bus level as a registered level.

`timescale 1ns/1ps
`default_nettype none

module lin_link_front (
    input  wire logic       lin_clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] lin_bus_dominant,
    input  wire logic [1:0] lin_wake_detect,
    output logic      [1:0] link_dom_level,
    output logic      [1:0] link_wake_toggle
);

    // ==========================================================
    // Reset brought into the link domain
    logic rst_m;
    logic rst_s;
    logic next_rst_m;
    logic next_rst_s;

    always_comb begin
        next_rst_m = rst_n;
        next_rst_s = rst_m;
    end

    always_ff @(posedge lin_clk) begin
        rst_m <= next_rst_m;
        rst_s <= next_rst_s;
    end

    // ==========================================================
    // Per-channel pin sampling and wake toggle
    for (genvar g = 0; g < 2; g++) begin : g_ch
        logic dom_m;
        logic dom_s;
        logic wk_m;
        logic wk_s;
        logic wk_q;
        logic tog;
        logic next_dom_m;
        logic next_dom_s;
        logic next_wk_m;
        logic next_wk_s;
        logic next_wk_q;
        logic next_tog;

        always_comb begin
            next_dom_m = lin_bus_dominant[g];
            next_dom_s = dom_m;
            next_wk_m  = lin_wake_detect[g];
            next_wk_s  = wk_m;
            next_wk_q  = wk_s;
            next_tog   = tog ^ (wk_s & ~wk_q);
            if (!rst_s) begin
                next_dom_s = 1'b0;
                next_wk_q  = 1'b0;
                next_tog   = 1'b0;
            end
        end

        always_ff @(posedge lin_clk) begin
            dom_m <= next_dom_m;
            dom_s <= next_dom_s;
            wk_m  <= next_wk_m;
            wk_s  <= next_wk_s;
            wk_q  <= next_wk_q;
            tog   <= next_tog;
        end

        assign link_dom_level[g]   = dom_s;
        assign link_wake_toggle[g] = tog;
    end

endmodule

`default_nettype wire

// ### rtl/lin_diagnostic_flags.sv
// Purpose: Diagnostic and status flags for two LIN channels.
// Assumes: Mode, read strobes come from clk-domain serial decode logic;
//          fault detector levels are asynchronous pins.
// Notes:   Bus level and wake events arrive on the link clock.
//
// Function
// [R1] Clamp flag sets after dominant timeout; clears after recovery and read.
// [R2] State flag is 1 in transmit/receive mode, 0 otherwise, in real time.
// [R3] State flag drops when commanded out or forced out by a transmit fault.
// [R4] Reading a channel's flags never changes its state flag.
// [R5] Wake-up receiver flag is 1 in sleep with wake enabled, else 0.
// [R6] Reading a channel's flags never changes its wake-up receiver flag.
// [R7] Wake source flag sets on a LIN wake event; clears on read.
// [R8] Short-to-ground flag sets on fault; clears on recovery plus read.
// [R9] Overtemperature flag sets while hot; clears once cool and read.
// [R10] Receive-pin-low flag sets on fault; clears on recovery plus read.
// [R11] Receive-pin-high flag sets on fault; clears on recovery plus read.
// [R12] Transmit-pin-dominant flag sets on fault; clears on recovery and read.
// [R13] LIN group bit 11 of fixed status set when a LIN channel is a source.
// [R14] Fixed status bit 5 marks second channel, bit 4 the first.
// [R15] Each channel keeps its own independent flags and read strobe.
// [R16] Read during a live fault keeps flag; first read after recovery clears.

`timescale 1ns/1ps
`default_nettype none

module lin_diagnostic_flags (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          lin_clk,
    input  wire logic [1:0]                    lin_bus_dominant,
    input  wire logic [1:0]                    lin_wake_detect,
    input  wire logic [1:0]                    lin_trx_mode,
    input  wire logic [1:0]                    lin_sleep,
    input  wire logic [1:0]                    lin_wake_en,
    input  wire logic [1:0]                    flag_read,
    input  wire logic [1:0][4:0]               fault_in,
    output logic      [1:0][8:0]               flag_data,
    output logic      [1:0]                    flag_data_valid,
    output logic      [1:0]                    lin_state,
    output logic      [1:0]                    lin_wu_rx,
    output logic      [15:0]                   fixed_status,
    output logic                               lin_group_bit,
    output logic                               first_channel_status_bit,
    output logic                               second_channel_status_bit
);

    // ==========================================================
    // Link-side front end
    logic [1:0] link_dom_level;
    logic [1:0] link_wake_toggle;

    lin_link_front u_front (
        .lin_clk          (lin_clk),
        .rst_n            (rst_n),
        .lin_bus_dominant (lin_bus_dominant),
        .lin_wake_detect  (lin_wake_detect),
        .link_dom_level   (link_dom_level),
        .link_wake_toggle (link_wake_toggle)
    );

    logic [1:0] pending;

    // ==========================================================
    // Per-channel flag logic
    for (genvar g = 0; g < lin_diag_pkg::CHANNELS; g++) begin : g_ch
        // Synchronisers
        logic                               dom_m;
        logic                               dom_s;
        logic                               tg_m;
        logic                               tg_s;
        logic                               tg_q;
        logic [lin_diag_pkg::FAULT_W-1:0]   flt_m;
        logic [lin_diag_pkg::FAULT_W-1:0]   flt_s;
        logic                               next_dom_m;
        logic                               next_dom_s;
        logic                               next_tg_m;
        logic                               next_tg_s;
        logic                               next_tg_q;
        logic [lin_diag_pkg::FAULT_W-1:0]   next_flt_m;
        logic [lin_diag_pkg::FAULT_W-1:0]   next_flt_s;

        // Flag state
        logic [lin_diag_pkg::DOM_CNT_W-1:0] dom_cnt;
        logic                               clamp;
        logic                               wake_src;
        logic [lin_diag_pkg::FAULT_W-1:0]   flt_flag;
        logic                               trx_q;
        logic                               forced_out;
        logic                               state;
        logic                               wu_rx;
        logic [lin_diag_pkg::FLAG_W-1:0]    rd_data;
        logic                               rd_valid;
        logic [lin_diag_pkg::DOM_CNT_W-1:0] next_dom_cnt;
        logic                               next_clamp;
        logic                               next_wake_src;
        logic [lin_diag_pkg::FAULT_W-1:0]   next_flt_flag;
        logic                               next_trx_q;
        logic                               next_forced_out;
        logic                               next_state;
        logic                               next_wu_rx;
        logic [lin_diag_pkg::FLAG_W-1:0]    next_rd_data;
        logic                               next_rd_valid;

        logic                               dom_timeout;
        logic                               wake_evt;
        logic                               rd;
        logic                               trx_entry;
        logic                               txd_fault;

        // ------------------------------------------------------
        // Bus level from the link side takes two flops
        always_comb begin
            next_dom_m = link_dom_level[g];
            next_dom_s = dom_m;
            if (!rst_n) begin
                next_dom_s = 1'b0;
            end
        end

        always_ff @(posedge clk) begin
            dom_m <= next_dom_m;
            dom_s <= next_dom_s;
        end

        // ------------------------------------------------------
        // Wake toggle takes two flops, a third finds its edges
        always_comb begin
            next_tg_m = link_wake_toggle[g];
            next_tg_s = tg_m;
            next_tg_q = tg_s;
            if (!rst_n) begin
                next_tg_s = 1'b0;
                next_tg_q = 1'b0;
            end
        end

        always_ff @(posedge clk) begin
            tg_m <= next_tg_m;
            tg_s <= next_tg_s;
            tg_q <= next_tg_q;
        end

        // ------------------------------------------------------
        // Fault detector pins take two flops
        always_comb begin
            next_flt_m = fault_in[g];
            next_flt_s = flt_m;
            if (!rst_n) begin
                next_flt_s = '0;
            end
        end

        always_ff @(posedge clk) begin
            flt_m <= next_flt_m;
            flt_s <= next_flt_s;
        end

        // ------------------------------------------------------
        // Conditions decoded once per cycle
        always_comb begin
            rd          = flag_read[g];                       // [R15]
            dom_timeout = (dom_cnt == lin_diag_pkg::DOM_LIMIT);
            wake_evt    = tg_s ^ tg_q;
            txd_fault   = flt_s[lin_diag_pkg::FLT_TXD_DOM];
            trx_entry   = lin_trx_mode[g] & ~trx_q;
        end

        // ------------------------------------------------------
        // Dominant time, counted while the bus stays low
        always_comb begin
            if (!dom_s) begin
                next_dom_cnt = '0;
            end else if (dom_timeout) begin
                next_dom_cnt = dom_cnt;
            end else begin
                next_dom_cnt = dom_cnt + 1'b1;
            end
            if (!rst_n) begin
                next_dom_cnt = '0;
            end
        end

        always_ff @(posedge clk) begin
            dom_cnt <= next_dom_cnt;
        end

        // ------------------------------------------------------
        // Clamp flag: a hardware set always beats a read clear
        always_comb begin
            next_clamp = (dom_s & dom_timeout) | (clamp & ~rd);  // [R1] [R16]
            if (!rst_n) begin
                next_clamp = 1'b0;
            end
        end

        always_ff @(posedge clk) begin
            clamp <= next_clamp;
        end

        // ------------------------------------------------------
        // Wake source flag: a new event beats a read clear
        always_comb begin
            next_wake_src = wake_evt | (wake_src & ~rd);  // [R7]
            if (!rst_n) begin
                next_wake_src = 1'b0;
            end
        end

        always_ff @(posedge clk) begin
            wake_src <= next_wake_src;
        end

        // ------------------------------------------------------
        // Fault flags: a live fault keeps its flag through reads
        // [R8] [R9] [R10] [R11] [R12] [R16]
        always_comb begin
            next_flt_flag = flt_s | (flt_flag & ~{lin_diag_pkg::FAULT_W{rd}});
            if (!rst_n) begin
                next_flt_flag = '0;
            end
        end

        always_ff @(posedge clk) begin
            flt_flag <= next_flt_flag;
        end

        // ------------------------------------------------------
        // Transmit fault holds the channel out until mode is re-entered
        always_comb begin
            next_trx_q = lin_trx_mode[g];
            if (txd_fault) begin
                next_forced_out = 1'b1;                       // [R3]
            end else if (trx_entry) begin
                next_forced_out = 1'b0;
            end else begin
                next_forced_out = forced_out;
            end
            if (!rst_n) begin
                next_trx_q      = 1'b0;
                next_forced_out = 1'b0;
            end
        end

        always_ff @(posedge clk) begin
            trx_q      <= next_trx_q;
            forced_out <= next_forced_out;
        end

        // ------------------------------------------------------
        // Real-time flags, independent of reads
        always_comb begin
            next_state = lin_trx_mode[g] & ~next_forced_out;  // [R2] [R3] [R4]
            next_wu_rx = lin_sleep[g] & lin_wake_en[g];       // [R5] [R6]
            if (!rst_n) begin
                next_state = 1'b0;
                next_wu_rx = 1'b0;
            end
        end

        always_ff @(posedge clk) begin
            state <= next_state;
            wu_rx <= next_wu_rx;
        end

        // ------------------------------------------------------
        // Snapshot of the flags as they stood before the clear
        always_comb begin
            next_rd_valid = rd;
            next_rd_data  = rd_data;
            if (rd) begin
                next_rd_data = {flt_flag, wake_src, wu_rx, state, clamp};
            end
            if (!rst_n) begin
                next_rd_valid = 1'b0;
                next_rd_data  = lin_diag_pkg::FLAGS_RST;
            end
        end

        always_ff @(posedge clk) begin
            rd_valid <= next_rd_valid;
            rd_data  <= next_rd_data;
        end

        assign flag_data[g]       = rd_data;
        assign flag_data_valid[g] = rd_valid;
        assign lin_state[g]       = state;
        assign lin_wu_rx[g]       = wu_rx;
        assign pending[g]         = clamp | wake_src | (|flt_flag);
    end

    // ==========================================================
    // Fixed status bits returned with every serial answer
    logic [15:0] fix;
    logic [15:0] next_fix;

    always_comb begin
        next_fix = lin_diag_pkg::FIX_RST;
        next_fix[lin_diag_pkg::FIX_LIN_GROUP] = |pending;    // [R13]
        next_fix[lin_diag_pkg::FIX_CH0]       = pending[0];  // [R14]
        next_fix[lin_diag_pkg::FIX_CH1]       = pending[1];  // [R14]
        if (!rst_n) begin
            next_fix = lin_diag_pkg::FIX_RST;
        end
    end

    always_ff @(posedge clk) begin
        fix <= next_fix;
    end

    assign fixed_status              = fix;
    assign lin_group_bit             = fix[lin_diag_pkg::FIX_LIN_GROUP];
    assign first_channel_status_bit  = fix[lin_diag_pkg::FIX_CH0];
    assign second_channel_status_bit = fix[lin_diag_pkg::FIX_CH1];

endmodule

`default_nettype wire

// ### bench/lin_link_model.sv
// Purpose: Far side of the link: link clock, bus level and wake pins.
// Assumes: Bench opens a frame with run.
// Notes:   Link clock stands still low outside frames.

`timescale 1ns/1ps
`default_nettype none

module lin_link_model (
    input  wire logic       run,
    input  wire logic [1:0] dom_req,
    input  wire logic [1:0] wake_req,
    output logic            lin_clk,
    output logic      [1:0] lin_bus_dominant,
    output logic      [1:0] lin_wake_detect
);
    // ==========================================================
    // Link clock, 12 ns, offset from the system clock
    initial begin
        lin_clk = 1'b0;
        #3;
        forever begin
            #6;
            lin_clk = run ? ~lin_clk : 1'b0;
        end
    end

    // ==========================================================
    // Pins move only with the link clock
    always @(posedge lin_clk) begin
        lin_bus_dominant <= dom_req;
        lin_wake_detect  <= wake_req;
    end
endmodule

`default_nettype wire

// ### bench/lin_diagnostic_flags_properties.sv
// Purpose: Port-level checks of the LIN flag bank.
// Assumes: Single system clock domain at the ports checked.
// Notes:   Fault pins need four samples before pending shows.

`timescale 1ns/1ps
`default_nettype none

module lin_flag_checker (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic [1:0]      lin_trx_mode,
    input  wire logic [1:0]      lin_sleep,
    input  wire logic [1:0]      lin_wake_en,
    input  wire logic [1:0]      flag_read,
    input  wire logic [1:0][4:0] fault_in,
    input  wire logic [1:0][8:0] flag_data,
    input  wire logic [1:0]      flag_data_valid,
    input  wire logic [1:0]      lin_state,
    input  wire logic [1:0]      lin_wu_rx,
    input  wire logic [15:0]     fixed_status,
    input  wire logic            lin_group_bit,
    input  wire logic            first_channel_status_bit,
    input  wire logic            second_channel_status_bit
);
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_read_valid: assert property (
        flag_read[0] |=> flag_data_valid[0])
        else $error("no valid after read");
    a_valid_cause: assert property (
        flag_data_valid[1] |-> $past(flag_read[1]))
        else $error("valid without read");
    a_data_holds: assert property (
        !flag_data_valid[0] |-> $stable(flag_data[0]))
        else $error("flag word moved without read");
    a_wake_rx_real: assert property ($past(rst_n) |->
        lin_wu_rx == $past(lin_sleep & lin_wake_en))
        else $error("wake receiver flag wrong");
    a_state_off: assert property (!lin_trx_mode[0] |=> !lin_state[0])
        else $error("state flag set outside mode");
    a_group_copy: assert property (
        lin_group_bit == fixed_status[11] &&
        first_channel_status_bit == fixed_status[4] &&
        second_channel_status_bit == fixed_status[5])
        else $error("status copies differ");
    a_group_any: assert property (
        fixed_status[11] == (fixed_status[4] | fixed_status[5]))
        else $error("group bit wrong");
    a_status_spare: assert property (
        (fixed_status & 16'hf7cf) == 16'h0000)
        else $error("spare status bit set");
    a_fault_pend0: assert property (
        fault_in[0][0] [*4] |=> fixed_status[4])
        else $error("channel 0 fault not pending");
    a_fault_pend1: assert property (
        fault_in[1][1] [*4] |=> fixed_status[5])
        else $error("channel 1 fault not pending");
endmodule

bind lin_diagnostic_flags lin_flag_checker i_chk (
    .clk, .rst_n, .lin_trx_mode, .lin_sleep, .lin_wake_en, .flag_read,
    .fault_in, .flag_data, .flag_data_valid, .lin_state, .lin_wu_rx,
    .fixed_status, .lin_group_bit, .first_channel_status_bit,
    .second_channel_status_bit
);

`default_nettype wire

// ### bench/test_lin_diagnostic_flags.sv
// Purpose: Self-checking bench for the LIN flag bank.
// Assumes: Inputs move at the falling clock edge.
// Notes:   Link clock runs only in reset and link scenarios.

`timescale 1ns/1ps
`default_nettype none

module test_lin_diagnostic_flags;
    logic            clk;
    logic            rst_n;
    logic            run;
    logic            lin_clk;
    logic [1:0]      dom_req, wake_req, dom, wake;
    logic [1:0]      trx, slp, wen, rd, fvalid, st, wu;
    logic [1:0][4:0] flt;
    logic [1:0][8:0] fdata;
    logic [15:0]     fix;
    logic            gbit, b1, b2;
    logic [8:0]      exp;
    int              bad_count, check_count;

    // ==========================================================
    // Clock, partner and design
    initial clk = 1'b0;
    always #20 clk = ~clk;

    lin_link_model i_link (.run(run), .dom_req(dom_req),
        .wake_req(wake_req), .lin_clk(lin_clk),
        .lin_bus_dominant(dom), .lin_wake_detect(wake));

    lin_diagnostic_flags i_dut (.clk(clk), .rst_n(rst_n),
        .lin_clk(lin_clk), .lin_bus_dominant(dom),
        .lin_wake_detect(wake), .lin_trx_mode(trx), .lin_sleep(slp),
        .lin_wake_en(wen), .flag_read(rd), .fault_in(flt),
        .flag_data(fdata), .flag_data_valid(fvalid), .lin_state(st),
        .lin_wu_rx(wu), .fixed_status(fix), .lin_group_bit(gbit),
        .first_channel_status_bit(b1), .second_channel_status_bit(b2));

    // ==========================================================
    // Tasks
    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic read(int c, logic [8:0] e);
        rd[c] = 1'b1;
        tick(1);
        rd[c] = 1'b0;
        chk("valid", 16'h0001, 16'(fvalid[c]));
        chk("flags", 16'(e), 16'(fdata[c]));
        tick(1);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog, far beyond the some 515 cycles of the tests
    initial begin
        tick(3000);
        bad_count++;
        close_out();
    end

    // ==========================================================
    // Tests
    initial begin
        rst_n = 1'b0;
        run = 1'b1;
        dom_req = 2'b00;
        wake_req = 2'b00;
        trx = 2'b00;
        slp = 2'b00;
        wen = 2'b00;
        rd = 2'b00;
        flt = '0;
        tick(4);
        rst_n = 1'b1;
        run = 1'b0;
        tick(1);
        chk("status", 16'h0000, fix);
        trx = 2'b01;
        slp = 2'b10;
        wen = 2'b10;
        tick(2);
        chk("state", 16'h0001, 16'(st));
        chk("wake rx", 16'h0002, 16'(wu));
        read(0, 9'h002);
        read(1, 9'h004);
        chk("state", 16'h0001, 16'(st));
        chk("wake rx", 16'h0002, 16'(wu));
        trx = 2'b00;
        wen = 2'b00;
        tick(2);
        chk("state", 16'h0000, 16'(st));
        chk("wake rx", 16'h0000, 16'(wu));
        slp = 2'b00;
        for (int c = 0; c < 2; c++) begin
            for (int g = 0; g < 5; g++) begin
                exp = 9'h010 << g;
                flt[c][g] = 1'b1;
                tick(5);
                chk("status", c ? 16'h0820 : 16'h0810, fix);
                chk("grp", c ? 16'h6 : 16'h5, 16'({gbit, b2, b1}));
                read(c, exp);
                read(c, exp);
                read(c ^ 1, 9'h000);
                flt[c][g] = 1'b0;
                tick(3);
                read(c, exp);
                read(c, 9'h000);
                tick(1);
                chk("status", 16'h0000, fix);
            end
        end
        trx = 2'b10;
        tick(2);
        chk("state", 16'h0002, 16'(st));
        flt[1][4] = 1'b1;
        tick(4);
        chk("state", 16'h0000, 16'(st));
        flt[1][4] = 1'b0;
        tick(3);
        read(1, 9'h100);
        trx = 2'b00;
        tick(1);
        trx = 2'b10;
        tick(2);
        chk("state", 16'h0002, 16'(st));
        trx = 2'b00;
        run = 1'b1;
        wake_req = 2'b10;
        tick(2);
        wake_req = 2'b00;
        tick(6);
        chk("status", 16'h0820, fix);
        read(1, 9'h008);
        read(1, 9'h000);
        dom_req = 2'b01;
        tick(240);
        chk("status", 16'h0000, fix);
        tick(20);
        chk("status", 16'h0810, fix);
        read(0, 9'h001);
        dom_req = 2'b00;
        tick(8);
        read(0, 9'h001);
        read(0, 9'h000);
        flt[0][0] = 1'b1;
        tick(5);
        chk("status", 16'h0810, fix);
        rst_n = 1'b0;
        flt = '0;
        tick(4);
        rst_n = 1'b1;
        tick(1);
        chk("status", 16'h0000, fix);
        read(0, 9'h000);
        run = 1'b0;
        close_out();
    end
endmodule

`default_nettype wire
